/* File: pkg/dpil_defs.svh */
/*
  Constants for the DRAM pin interface lanes block: size and width codes,
  field layout of the timing configuration word and address split.
  Assumes nothing beyond being included once by the package and the core.
*/
`ifndef DPIL_DEFS_SVH
`define DPIL_DEFS_SVH

// =============================================================
// Transfer size codes.
`define DPIL_SIZE_LONG   2'h0
`define DPIL_SIZE_BYTE   2'h1
`define DPIL_SIZE_WORD   2'h2
`define DPIL_SIZE_LINE   2'h3

// =============================================================
// Port width codes.
`define DPIL_PORT_32     2'h0
`define DPIL_PORT_8      2'h1
`define DPIL_PORT_16     2'h2

// =============================================================
// Column strobe patterns, bit 3 is the lane on D[31:24].
`define DPIL_CAS_NONE    4'hf
`define DPIL_CAS_P8      4'h7
`define DPIL_CAS_P16     4'h3
`define DPIL_CAS_P32     4'h0

// =============================================================
// Timing configuration word: [4] mux enable, [3:2] row wait, [1:0] column wait.
`define DPIL_TC_MUX_BIT  4
`define DPIL_TC_RCD_MSB  3
`define DPIL_TC_RCD_LSB  2
`define DPIL_TC_CAS_MSB  1
`define DPIL_TC_CAS_LSB  0
`define DPIL_TC_RESET    5'h00

// =============================================================
// Address pins and row address split.
`define DPIL_FIXED_PINS  24'hffffff
`define DPIL_ROW_SHIFT   11

`endif

/* File: pkg/dpil_pkg.sv */
/*
  Types of the DRAM pin interface lanes block.
  Assumes dpil_defs.svh is on the include path.
*/
`include "dpil_defs.svh"

package dpil_pkg;

  // States, Gray coded along idle, row, column, precharge.
  typedef enum logic [2:0] {
    DPIL_IDLE = 3'h0,
    DPIL_ROW  = 3'h1,
    DPIL_COL  = 3'h3,
    DPIL_PRE  = 3'h2,
    DPIL_REF  = 3'h6
  } dpil_state_t;

  // One transfer or refresh request from the internal bus.
  typedef struct packed {
    logic        start;
    logic        refresh;
    logic [1:0]  transfer_size_code;
    logic [1:0]  port_width;
    logic [27:0] addr;
    logic        write;
    logic        ext_master;
  } dpil_req_t;

  // Pins toward the DRAM banks.
  typedef struct packed {
    logic [3:0]  cas_n;
    logic        ras_n;
    logic        dram_write_strobe_n;
    logic [27:0] addr_o;
    logic [27:0] addr_oe;
  } dpil_pins_t;

  // Whole state of the core.
  typedef struct packed {
    dpil_state_t state;
    logic [1:0]  cnt;
    dpil_pins_t  pins;
    logic [3:0]  lanes_n;
    logic [27:0] col;
    logic        done;
  } dpil_core_t;

endpackage : dpil_pkg

/* File: core/dpil_core.sv */
/*
  Pin-level DRAM interface: column strobes per byte lane, DRAM write strobe,
  multiplexed row and column address with pin enables, and refresh cycles.
  Assumes requests arrive synchronous to clk and are held off while busy.
*/
// Function
// - Longword and line: one strobe for 8-bit, two for 16-bit, four for 32-bit.
// - Strobe timing is stretched by the timing configuration word.
// - DRAM write strobe low in write cycles, high in read cycles.
// - DRAM write strobe stays high during refresh.
// - DRAM write strobe covers DRAM transfers only.
// - Address driven only on address pins; upper four per pin configuration.
// - Core transfers get row and column address driven by the block.
// - External master transfers muxed only when the mux enable bit is set.
// - Each bank is 8, 16 or 32 bits wide; strobes follow the width.
`include "dpil_defs.svh"

module dpil_core
  import dpil_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Request side.
  input  wire dpil_req_t  req,
  input  wire logic [4:0] dram_timing_config,
  input  wire logic [3:0] pin_assignment_config,
  output logic            busy,
  output logic            done,
  // DRAM side.
  output dpil_pins_t      pins
);

  // ===========================================================
  // Lane decode.

  // Active-low strobe pattern for a size, width and low address.
  function automatic logic [3:0] dpil_lanes(input logic [1:0] sz, input logic [1:0] pw,
                                            input logic [1:0] a);
    logic [3:0] r;
    r = `DPIL_CAS_NONE;
    case (pw)
      `DPIL_PORT_8: r = `DPIL_CAS_P8;
      `DPIL_PORT_16: begin
        if (sz == `DPIL_SIZE_BYTE) begin
          r = a[0] ? 4'hb : 4'h7;
        end else begin
          r = `DPIL_CAS_P16;
        end
      end
      default: begin
        case (sz)
          `DPIL_SIZE_BYTE: r = ~(4'h8 >> a);
          `DPIL_SIZE_WORD: r = a[1] ? 4'hc : 4'h3;
          default:         r = `DPIL_CAS_P32;
        endcase
      end
    endcase
    return r;
  endfunction : dpil_lanes

  // ===========================================================
  // State.

  dpil_core_t s_reg;
  dpil_core_t s_next;
  logic       mux_ok;
  logic [1:0] rcd_wait;
  logic [1:0] cas_wait;

  assign mux_ok   = !req.ext_master || dram_timing_config[`DPIL_TC_MUX_BIT];
  assign rcd_wait = dram_timing_config[`DPIL_TC_RCD_MSB:`DPIL_TC_RCD_LSB];
  assign cas_wait = dram_timing_config[`DPIL_TC_CAS_MSB:`DPIL_TC_CAS_LSB];

  // Next state of the whole pin sequencer.
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.state)
      DPIL_IDLE: begin
        s_next.pins.cas_n   = `DPIL_CAS_NONE;
        s_next.pins.ras_n   = 1'b1;
        s_next.pins.dram_write_strobe_n = 1'b1;
        s_next.pins.addr_oe = '0;
        if (req.refresh) begin
          s_next.state      = DPIL_REF;
          s_next.cnt        = cas_wait;
          s_next.pins.cas_n = `DPIL_CAS_P32;
          s_next.pins.dram_write_strobe_n = 1'b1;
        end else if (req.start) begin
          s_next.state        = DPIL_ROW;
          s_next.cnt          = rcd_wait;
          s_next.pins.ras_n   = 1'b0;
          s_next.pins.dram_write_strobe_n = !req.write;
          s_next.lanes_n      = dpil_lanes(req.transfer_size_code, req.port_width,
                                           req.addr[1:0]);
          s_next.col          = req.addr;
          s_next.pins.addr_o  = req.addr >> `DPIL_ROW_SHIFT;
          if (mux_ok) begin
            s_next.pins.addr_oe = {pin_assignment_config, `DPIL_FIXED_PINS};
          end
        end
      end
      DPIL_ROW: begin
        if (s_reg.cnt == 2'h0) begin
          s_next.state       = DPIL_COL;
          s_next.cnt         = cas_wait;
          s_next.pins.cas_n  = s_reg.lanes_n;
          s_next.pins.addr_o = s_reg.col;
        end else begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      DPIL_COL: begin
        if (s_reg.cnt == 2'h0) begin
          s_next.state        = DPIL_PRE;
          s_next.pins.cas_n   = `DPIL_CAS_NONE;
          s_next.pins.ras_n   = 1'b1;
          s_next.pins.dram_write_strobe_n = 1'b1;
          s_next.pins.addr_oe = '0;
          s_next.done         = 1'b1;
        end else begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      DPIL_REF: begin
        s_next.pins.ras_n = 1'b0;
        if (!s_reg.pins.ras_n && s_reg.cnt == 2'h0) begin
          s_next.state      = DPIL_PRE;
          s_next.pins.cas_n = `DPIL_CAS_NONE;
          s_next.pins.ras_n = 1'b1;
        end else if (!s_reg.pins.ras_n) begin
          s_next.cnt = s_reg.cnt - 2'h1;
        end
      end
      DPIL_PRE: s_next.state = DPIL_IDLE;
      default:  s_next.state = DPIL_IDLE;
    endcase
  end

  // Register the state; reset parks every pin negated.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_reg <= '{state: DPIL_IDLE, cnt: 2'h0,
                 pins: '{cas_n: 4'hf, ras_n: 1'b1, dram_write_strobe_n: 1'b1,
                         addr_o: 28'h0, addr_oe: 28'h0},
                 lanes_n: 4'hf, col: 28'h0, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs.
  assign pins = s_reg.pins;
  assign busy = (s_reg.state != DPIL_IDLE);
  assign done = s_reg.done;

  // ===========================================================
  // Checks.

  property p_lane_long;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_IDLE && req.start && !req.refresh && req.port_width == `DPIL_PORT_16
       && req.transfer_size_code == `DPIL_SIZE_LONG && rcd_wait == 2'h0)
      |=> ##1 pins.cas_n == `DPIL_CAS_P16;
  endproperty
  a_lane_long: assert property (p_lane_long) else $error("16-bit longword strobes wrong");

  property p_row_time;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_ROW && s_reg.cnt == 2'h2) |=> ##1 s_reg.state == DPIL_ROW ##1
      s_reg.state == DPIL_COL;
  endproperty
  a_row_time: assert property (p_row_time) else $error("row wait not honoured");

  property p_we_write;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_COL) |-> pins.dram_write_strobe_n == $past(pins.dram_write_strobe_n);
  endproperty
  a_we_write: assert property (p_we_write) else $error("write strobe moved mid cycle");

  property p_we_ref;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_REF) |-> pins.dram_write_strobe_n && !(&pins.cas_n);
  endproperty
  a_we_ref: assert property (p_we_ref) else $error("write strobe low in refresh");

  property p_we_idle;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_IDLE) |-> pins.dram_write_strobe_n && &pins.cas_n;
  endproperty
  a_we_idle: assert property (p_we_idle) else $error("strobes active when idle");

  property p_upper_pins;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_IDLE && req.start && !req.refresh)
      |=> (pins.addr_oe[27:24] & ~$past(pin_assignment_config)) == 4'h0;
  endproperty
  a_upper_pins: assert property (p_upper_pins) else $error("non-address pin driven");

  property p_core_mux;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_IDLE && req.start && !req.refresh && !req.ext_master)
      |=> pins.addr_oe[23:0] == `DPIL_FIXED_PINS && !pins.ras_n;
  endproperty
  a_core_mux: assert property (p_core_mux) else $error("core row address not driven");

  property p_ext_mux;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_IDLE && req.start && !req.refresh && req.ext_master
       && !dram_timing_config[`DPIL_TC_MUX_BIT]) |=> pins.addr_oe == 28'h0 [*2];
  endproperty
  a_ext_mux: assert property (p_ext_mux) else $error("external address muxed");

  property p_width8;
    @(posedge clk) disable iff (sys_rst)
      (s_reg.state == DPIL_IDLE && req.start && !req.refresh && req.port_width == `DPIL_PORT_8)
      |=> (s_reg.lanes_n == `DPIL_CAS_P8);
  endproperty
  a_width8: assert property (p_width8) else $error("8-bit port uses other lanes");

endmodule : dpil_core

/* File: test/dpil_dram_model.sv */
/*
  Behavioural DRAM bank that latches what the controller presents at its pins.
  Assumes the pins are registered on the rising edge of clk.
*/
module dpil_dram_model
  import dpil_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Pins from the controller.
  input  wire dpil_pins_t  pins,
  // What the bank latched at each strobe fall.
  output logic [27:0]      row_seen,
  output logic [27:0]      oe_seen,
  output logic [27:0]      col_seen,
  output logic [3:0]       lanes_seen,
  output logic             we_ras,
  output logic             we_cas
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ras_q = 1'b1;
  logic cas_q = 1'b1;

  // =============================================================
  // Strobe capture
  // Latch row and column on the falling strobes, as a real bank would.
  always @(posedge clk) begin
    ras_q <= pins.ras_n;
    cas_q <= &pins.cas_n;
    if (ras_q && !pins.ras_n) begin
      row_seen <= pins.addr_o;
      oe_seen  <= pins.addr_oe;
      we_ras   <= pins.dram_write_strobe_n;
    end
    if (cas_q && !(&pins.cas_n)) begin
      col_seen   <= pins.addr_o;
      lanes_seen <= pins.cas_n;
      we_cas     <= pins.dram_write_strobe_n;
    end
  end
endmodule : dpil_dram_model

/* File: test/dpil_bench.sv */
/*
  Self-checking bench for the DRAM pin interface core with a bank model.
  Assumes dpil_defs.svh is on the include path.
*/
`include "dpil_defs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module dpil_bench
  import dpil_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  dpil_req_t   req = '0;
  logic [4:0]  dram_timing_config = 5'h00;
  logic [3:0]  pin_assignment_config = 4'h0;
  logic        busy;
  logic        done;
  dpil_pins_t  pins;
  logic [27:0] row_seen, oe_seen, col_seen;
  logic [3:0]  lanes_seen;
  logic        we_ras, we_cas;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n;

  // =============================================================
  // Instances
  dpil_core i_dpil_core (.clk(clk), .sys_rst(sys_rst), .req(req),
    .dram_timing_config(dram_timing_config), .pin_assignment_config(pin_assignment_config),
    .busy(busy), .done(done), .pins(pins));
  dpil_dram_model i_dpil_dram_model (.clk(clk), .pins(pins), .row_seen(row_seen),
    .oe_seen(oe_seen), .col_seen(col_seen), .lanes_seen(lanes_seen),
    .we_ras(we_ras), .we_cas(we_cas));

  // Clock at 125 MHz.
  initial begin
    forever #4 clk = ~clk;
  end

  // =============================================================
  // Tasks
  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // One request; n counts falling edges after the taking edge until done shows,
  // one less than the rising edges from the taking edge to the one that samples done.
  task automatic xfer(input logic rf, input logic [1:0] sz, input logic [1:0] pw,
                      input logic [27:0] a, input logic wr, input logic ext,
                      input logic [4:0] tc, input logic [3:0] pa);
    @(negedge clk);
    req = '{start: !rf, refresh: rf, transfer_size_code: sz, port_width: pw,
            addr: a, write: wr, ext_master: ext};
    dram_timing_config = tc;
    pin_assignment_config = pa;
    @(negedge clk);
    req.start = 1'b0;
    req.refresh = 1'b0;
    `CHK("busy", 1'b1, busy)
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask : xfer

  // Long and line transfers on every width, unaligned address.
  task automatic t_lanes();
    logic [1:0] pw [3] = '{`DPIL_PORT_8, `DPIL_PORT_16, `DPIL_PORT_32};
    logic [3:0] ex [3] = '{`DPIL_CAS_P8, `DPIL_CAS_P16, `DPIL_CAS_P32};
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, (i < 3) ? `DPIL_SIZE_LONG : `DPIL_SIZE_LINE, pw[i % 3], 28'h0000003,
           1'b0, 1'b0, 5'h00, 4'h0);
      `CHK("lanes", ex[i % 3], lanes_seen)
      `CHK("done_lat", 2, n)
    end
  endtask : t_lanes

  // Write strobe follows the direction of DRAM transfers.
  task automatic t_dir();
    for (int w = 0; w < 2; w++) begin
      xfer(1'b0, `DPIL_SIZE_LONG, `DPIL_PORT_32, 28'h0000100, w[0], 1'b0, 5'h00, 4'h0);
      `CHK("we_row", !w[0], we_ras)
      `CHK("we_col", !w[0], we_cas)
    end
  endtask : t_dir

  // Refresh keeps the write strobe high even with write requested.
  task automatic t_refresh();
    xfer(1'b1, `DPIL_SIZE_LONG, `DPIL_PORT_32, 28'h0, 1'b1, 1'b0, 5'h00, 4'h0);
    `CHK("ref_we_row", 1'b1, we_ras)
    `CHK("ref_we_col", 1'b1, we_cas)
    `CHK("ref_lanes", 4'h0, lanes_seen)
  endtask : t_refresh

  // Address pins, row and column for core and external masters.
  task automatic t_addr(input logic ext, input logic [4:0] tc, input logic [3:0] pa,
                        input logic drv);
    logic [27:0] a;
    logic [27:0] oe_e;
    a = 28'hfedcba9;
    oe_e = drv ? {pa, `DPIL_FIXED_PINS} : 28'h0;
    xfer(1'b0, `DPIL_SIZE_LONG, `DPIL_PORT_32, a, 1'b0, ext, tc, pa);
    `CHK("addr_oe", oe_e, oe_seen)
    `CHK("row", (a >> `DPIL_ROW_SHIFT) & oe_e, row_seen & oe_e)
    `CHK("col", a & oe_e, col_seen & oe_e)
  endtask : t_addr

  // Row and column waits stretch the cycle.
  task automatic t_timing();
    logic [1:0] rc [3] = '{2'h3, 2'h1, 2'h2};
    logic [1:0] cc [3] = '{2'h3, 2'h2, 2'h0};
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, `DPIL_SIZE_WORD, `DPIL_PORT_16, 28'h0000002, 1'b0, 1'b0,
           {1'b0, rc[i], cc[i]}, 4'h0);
      `CHK("done_lat", 2 + rc[i] + cc[i], n)
    end
  endtask : t_timing

  // Narrow transfers pick the lane that their address names.
  task automatic t_narrow();
    xfer(1'b0, `DPIL_SIZE_BYTE, `DPIL_PORT_32, 28'h0000001, 1'b0, 1'b0, 5'h00, 4'h0);
    `CHK("byte32", 4'hb, lanes_seen)
    xfer(1'b0, `DPIL_SIZE_WORD, `DPIL_PORT_32, 28'h0000002, 1'b0, 1'b0, 5'h00, 4'h0);
    `CHK("word32", 4'hc, lanes_seen)
    xfer(1'b0, `DPIL_SIZE_BYTE, `DPIL_PORT_16, 28'h0000001, 1'b0, 1'b0, 5'h00, 4'h0);
    `CHK("byte16", 4'hb, lanes_seen)
  endtask : t_narrow

  // =============================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    `CHK("rst_cas", `DPIL_CAS_NONE, pins.cas_n)
    `CHK("rst_oe", 28'h0, pins.addr_oe)
    t_lanes();
    t_narrow();
    t_dir();
    t_refresh();
    t_addr(1'b0, 5'h00, 4'ha, 1'b1);
    t_addr(1'b1, 5'h00, 4'hf, 1'b0);
    t_addr(1'b1, 5'h10, 4'h5, 1'b1);
    t_timing();
    end_sim();
  end

  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule : dpil_bench
